// file: hdl/ibsd_pkg.sv
// Constants and types for the interrupt message bus status decoder.
// Assumes one bus cycle per i_clk cycle, counted on the synchronised pins.
package ibsd_pkg;

    // ---------------------------------------------------------------
    // Cycle numbering
    // ---------------------------------------------------------------
    localparam int CYC_W = 6;
    localparam logic [CYC_W-1:0] CYC_FIRST = 6'h01;
    localparam logic [CYC_W-1:0] CYC_CS_FIRST = 6'h06;
    localparam logic [CYC_W-1:0] CYC_MODE_LATCH = 6'h08;
    localparam logic [CYC_W-1:0] EOI_CS_LAST = 6'h09;
    localparam logic [CYC_W-1:0] EOI_CS_CHK = 6'h0a;
    localparam logic [CYC_W-1:0] EOI_STAT0 = 6'h0c;
    localparam logic [CYC_W-1:0] EOI_STAT1 = 6'h0d;
    localparam logic [CYC_W-1:0] EOI_LEN = 6'h0e;
    localparam logic [CYC_W-1:0] SH_CS_LAST = 6'h10;
    localparam logic [CYC_W-1:0] SH_CS_CHK = 6'h11;
    localparam logic [CYC_W-1:0] SH_STAT0 = 6'h13;
    localparam logic [CYC_W-1:0] SH_STAT1 = 6'h14;
    localparam logic [CYC_W-1:0] SH_LEN = 6'h15;
    localparam logic [CYC_W-1:0] LOW_STAT2 = 6'h21;
    localparam logic [CYC_W-1:0] LOW_LEN = 6'h22;

    // ---------------------------------------------------------------
    // Status pair codes (upper bit from line 1)
    // ---------------------------------------------------------------
    localparam logic [1:0] PAIR_START = 2'h1;
    localparam logic [1:0] PAIR_CS_OK = 2'h0;
    localparam logic [1:0] PAIR_ACCEPT = 2'h2;
    localparam logic [1:0] PAIR_RETRY = 2'h3;
    localparam logic [1:0] PAIR_FOCUS = 2'h2;
    localparam logic [1:0] PAIR_CS_ERR = 2'h3;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_EOI = 2'b00,
        MODE_FIXED = 2'b01,
        MODE_OTHER = 2'b10,
        MODE_LOWEST = 2'b11
    } ibsd_mode_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } ibsd_state_e;

endpackage : ibsd_pkg

// file: hdl/ibsd_status_decoder.sv
// Status cycle interpreter for one agent on a two-line interrupt message bus.
// Assumes i_clk is the bus clock; pins are asynchronous and synchronised here.
// What this block does
// - Sample both status pairs per mode and focus
// - END_OF_INTERRUPT_MSG accept: update at 13, 14 cycles
// - END_OF_INTERRUPT_MSG retry pair: update at 13, retry
// - Non-lowest first pair 0X: no update, retry
// - Checksum error pairs: no update, retry
// - Fixed accept: update at 20, 21 cycles
// - Other short modes behave like fixed
// - Lowest, no focus, 11 then 10: accept
// - Lowest final pair 11 or 0X: retry
// - Lowest first pair 10: update, retry
// - Lowest first pair 0X: no update, retry
// - Lowest checksum pair 10: focus, accept
// - Running checksum; mismatch drives 11
// - Lowest focus agent drives 10 at cycle 19, unless mismatch drives 11
`timescale 1ns/1ns
module ibsd_status_decoder
    import ibsd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Bus lines, asynchronous
    input wire logic i_bus_line1,
    input wire logic i_bus_line2,
    // Own side, same clock
    input wire logic [1:0] i_msg_mode,
    input wire logic i_focus_agent,
    // Bus drive, open drain
    output logic o_bus_drv1,
    output logic o_bus_drv2,
    output logic o_bus_oe_n,
    // Message results
    output logic o_arbitration_id_update,
    output logic o_msg_done,
    output logic o_msg_accept,
    output logic o_msg_retry,
    output logic [5:0] o_msg_len,
    output logic o_no_focus_agent
);

    // ---------------------------------------------------------------
    // Pin synchroniser
    // ---------------------------------------------------------------
    logic [1:0] meta_r, pair_r, pair_s;

    // Two flops per line; only the second stage is read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_r <= 2'h0;
            pair_r <= 2'h0;
        end else begin
            meta_r <= {i_bus_line1, i_bus_line2};
            pair_r <= meta_r;
        end
    end
    assign pair_s = pair_r;

    // ---------------------------------------------------------------
    // Decoding helpers
    // ---------------------------------------------------------------
    function automatic logic [CYC_W-1:0] pick_cyc(input ibsd_mode_e m, input logic [CYC_W-1:0] eoi_c,
                                                   input logic [CYC_W-1:0] sh_c);
        pick_cyc = (m == MODE_EOI) ? eoi_c : sh_c;
    endfunction : pick_cyc

    // Returns {update, retry, wait_final} for checksum pair and first pair
    function automatic logic [2:0] decide(input ibsd_mode_e m, input logic [1:0] cs, input logic [1:0] a1);
        decide = 3'b010;
        if (cs == PAIR_CS_OK && a1 == PAIR_RETRY) begin
            decide = (m == MODE_LOWEST) ? 3'b101 : 3'b110;
        end else if (cs == PAIR_CS_OK && a1 == PAIR_ACCEPT) begin
            decide = (m == MODE_LOWEST) ? 3'b110 : 3'b100;
        end else if (cs == PAIR_FOCUS && m == MODE_LOWEST) begin
            decide = 3'b100;
        end
    endfunction : decide

    // ---------------------------------------------------------------
    // Message sequencer state
    // ---------------------------------------------------------------
    ibsd_state_e state_r, state_nxt;
    ibsd_mode_e mode_r, mode_nxt;
    logic [CYC_W-1:0] cnt_r, cnt_nxt;
    logic [CYC_W-1:0] len_r, len_nxt;
    logic [1:0] cs_sum_r, cs_sum_nxt;
    logic cs_err_r, cs_err_nxt;
    logic [1:0] cs_pair_r, cs_pair_nxt;
    logic wait_r, wait_nxt;
    logic retry_r, retry_nxt;
    logic [1:0] drv_r, drv_nxt;
    logic oe_n_r, oe_n_nxt;
    logic upd_r, upd_nxt;
    logic done_r, done_nxt;
    logic acc_out_r, acc_out_nxt;
    logic retry_out_r, retry_out_nxt;
    logic [5:0] len_out_r, len_out_nxt;
    logic no_focus_agent_r, no_focus_agent_nxt;
    logic [2:0] sum3, verdict;
    logic run;
    logic [CYC_W-1:0] chk_cyc, stat0_cyc, stat1_cyc;

    assign run = (state_r == ST_RUN);
    assign chk_cyc = pick_cyc(mode_r, EOI_CS_CHK, SH_CS_CHK);
    assign stat0_cyc = pick_cyc(mode_r, EOI_STAT0, SH_STAT0);
    assign stat1_cyc = pick_cyc(mode_r, EOI_STAT1, SH_STAT1);
    assign sum3 = {1'b0, cs_sum_r} + {1'b0, pair_s};
    assign verdict = decide(mode_r, cs_pair_r, pair_s);

    // Next values: counting, checksum, status decoding and drive
    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        len_nxt = len_r;
        cs_sum_nxt = cs_sum_r;
        cs_err_nxt = cs_err_r;
        cs_pair_nxt = cs_pair_r;
        wait_nxt = wait_r;
        retry_nxt = retry_r;
        drv_nxt = 2'h0;
        oe_n_nxt = 1'b1;
        upd_nxt = 1'b0;
        done_nxt = 1'b0;
        acc_out_nxt = acc_out_r;
        retry_out_nxt = retry_out_r;
        len_out_nxt = len_out_r;
        no_focus_agent_nxt = no_focus_agent_r;
        if (!run) begin
            // Start pair marks cycle 1 of a new message
            if (pair_s == PAIR_START) begin
                state_nxt = ST_RUN;
                cnt_nxt = CYC_FIRST + 6'h01;
                len_nxt = SH_LEN;
                cs_sum_nxt = 2'h0;
                cs_err_nxt = 1'b0;
                wait_nxt = 1'b0;
                retry_nxt = 1'b1;
                no_focus_agent_nxt = 1'b0;
            end
        end else begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == CYC_MODE_LATCH) begin
                mode_nxt = ibsd_mode_e'(i_msg_mode);
                len_nxt = (ibsd_mode_e'(i_msg_mode) == MODE_EOI) ? EOI_LEN : SH_LEN;
            end
            // Carry folds back on all but the last covered cycle
            if (cnt_r >= CYC_CS_FIRST && cnt_r < chk_cyc) begin
                cs_sum_nxt = (cnt_r == pick_cyc(mode_r, EOI_CS_LAST, SH_CS_LAST)) ? sum3[1:0]
                             : sum3[1:0] + {1'b0, sum3[2]};
            end
            if (cnt_r == chk_cyc) begin
                cs_err_nxt = (pair_s != cs_sum_r);
            end
            // Drive for the checksum status cycle, visible one clock later
            if (cnt_r == stat0_cyc - 6'h01) begin
                if (cs_err_r) begin
                    drv_nxt = PAIR_CS_ERR;
                    oe_n_nxt = 1'b0;
                end else if (mode_r == MODE_LOWEST && i_focus_agent) begin
                    drv_nxt = PAIR_FOCUS;
                    oe_n_nxt = 1'b0;
                end
            end
            if (cnt_r == stat0_cyc) begin
                cs_pair_nxt = pair_s;
                if (mode_r == MODE_LOWEST) begin
                    len_nxt = (pair_s == PAIR_CS_OK || pair_s == PAIR_FOCUS) ? LOW_LEN : len_r;
                    no_focus_agent_nxt = (pair_s == PAIR_CS_OK);
                end
            end
            if (cnt_r == stat1_cyc) begin
                upd_nxt = verdict[2];
                retry_nxt = verdict[1];
                wait_nxt = verdict[0];
            end
            if (cnt_r == LOW_STAT2 && wait_r) begin
                retry_nxt = (pair_s != PAIR_ACCEPT);
            end
            if (cnt_r == len_r) begin
                state_nxt = ST_IDLE;
                cnt_nxt = 6'h00;
                done_nxt = 1'b1;
                acc_out_nxt = !retry_nxt;
                retry_out_nxt = retry_nxt;
                len_out_nxt = len_r;
            end
        end
    end

    // Registers only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
            mode_r <= MODE_FIXED;
            cnt_r <= 6'h00;
            len_r <= SH_LEN;
            cs_sum_r <= 2'h0;
            cs_err_r <= 1'b0;
            cs_pair_r <= 2'h0;
            wait_r <= 1'b0;
            retry_r <= 1'b0;
            drv_r <= 2'h0;
            oe_n_r <= 1'b1;
            upd_r <= 1'b0;
            done_r <= 1'b0;
            acc_out_r <= 1'b0;
            retry_out_r <= 1'b0;
            len_out_r <= 6'h00;
            no_focus_agent_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            len_r <= len_nxt;
            cs_sum_r <= cs_sum_nxt;
            cs_err_r <= cs_err_nxt;
            cs_pair_r <= cs_pair_nxt;
            wait_r <= wait_nxt;
            retry_r <= retry_nxt;
            drv_r <= drv_nxt;
            oe_n_r <= oe_n_nxt;
            upd_r <= upd_nxt;
            done_r <= done_nxt;
            acc_out_r <= acc_out_nxt;
            retry_out_r <= retry_out_nxt;
            len_out_r <= len_out_nxt;
            no_focus_agent_r <= no_focus_agent_nxt;
        end
    end

    // Outputs straight from flops
    assign o_bus_drv1 = drv_r[1];
    assign o_bus_drv2 = drv_r[0];
    assign o_bus_oe_n = oe_n_r;
    assign o_arbitration_id_update = upd_r;
    assign o_msg_done = done_r;
    assign o_msg_accept = acc_out_r;
    assign o_msg_retry = retry_out_r;
    assign o_msg_len = len_out_r;
    assign o_no_focus_agent = no_focus_agent_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_stat1(ibsd_mode_e m, logic [1:0] cs, logic [1:0] a1);
        run && mode_r == m && cnt_r == stat1_cyc && cs_pair_r == cs && pair_s == a1;
    endsequence
    sequence s_end_ok;
        o_msg_done && o_msg_accept && !o_msg_retry;
    endsequence
    sequence s_end_retry;
        o_msg_done && !o_msg_accept && o_msg_retry;
    endsequence

    a_eoi_accept: assert property (s_stat1(MODE_EOI, 2'h0, 2'h2) |=> o_arbitration_id_update ##1 s_end_ok)
        else $error("eoi accept not finished at cycle 14");
    a_eoi_retry: assert property (s_stat1(MODE_EOI, 2'h0, 2'h3) |=> o_arbitration_id_update ##1 s_end_retry)
        else $error("eoi retry not finished at cycle 14");
    a_acc_err_norm: assert property (run && mode_r != MODE_LOWEST && cnt_r == stat1_cyc
                                     && cs_pair_r == 2'h0 && !pair_s[1] |=> !o_arbitration_id_update)
        else $error("accept error updated arbitration id");
    a_cs_err_low: assert property (run && mode_r == MODE_LOWEST && cnt_r == SH_STAT1
                                   && cs_pair_r[0] |=> !o_arbitration_id_update ##1 s_end_retry)
        else $error("lowest checksum error not 21 cycles with retry");
    a_fixed_accept: assert property (s_stat1(MODE_FIXED, 2'h0, 2'h2) |=> o_arbitration_id_update ##1 s_end_ok)
        else $error("fixed accept not finished at cycle 21");
    a_other_retry: assert property (s_stat1(MODE_OTHER, 2'h0, 2'h3) |=> o_arbitration_id_update ##1 s_end_retry)
        else $error("short retry not finished at cycle 21");
    a_low_final_ok: assert property (run && wait_r && cnt_r == LOW_STAT2 && pair_s == PAIR_ACCEPT
                                     |=> ##1 (s_end_ok and o_msg_len == LOW_LEN))
        else $error("lowest final accept not honoured");
    a_low_final_err: assert property (run && wait_r && cnt_r == LOW_STAT2 && pair_s != PAIR_ACCEPT
                                      |=> ##1 s_end_retry)
        else $error("lowest final error not retried");
    a_low_end_retry: assert property (s_stat1(MODE_LOWEST, 2'h0, 2'h2) |=> o_arbitration_id_update ##14 s_end_retry)
        else $error("lowest end and retry wrong");
    a_low_first_err: assert property (run && mode_r == MODE_LOWEST && cnt_r == SH_STAT1
                                      && cs_pair_r == 2'h0 && !pair_s[1] |=> !o_arbitration_id_update)
        else $error("lowest first error updated arbitration id");
    a_low_focus: assert property (run && mode_r == MODE_LOWEST && cnt_r == SH_STAT1
                                  && cs_pair_r == 2'h2 |=> o_arbitration_id_update ##14 s_end_ok)
        else $error("focus message not accepted");
    a_cs_drive: assert property (run && cnt_r == chk_cyc && pair_s != cs_sum_r
                                 |=> ##1 !o_bus_oe_n && o_bus_drv1 && o_bus_drv2)
        else $error("checksum mismatch not driven as 11");
    a_focus_drive: assert property (run && mode_r == MODE_LOWEST && cnt_r == SH_STAT0 - 6'h01
                                    && !cs_err_r && i_focus_agent |=> !o_bus_oe_n && o_bus_drv1 && !o_bus_drv2)
        else $error("focus agent did not drive 10");

endmodule : ibsd_status_decoder

// file: sim/ibsd_bus_agent_model.sv
// Behavioural model of the other agents sharing the two-line message bus.
// Assumes the bench holds the frame settings stable while a frame runs.
`timescale 1ns/1ns
module ibsd_bus_agent_model (
    // Clock and frame request
    input wire logic i_clk,
    input wire logic i_start,
    // Frame settings
    input wire logic [1:0] i_mode,
    input wire logic [1:0] i_cs_pair,
    input wire logic [1:0] i_a1,
    input wire logic [1:0] i_a2,
    input wire logic i_cs_bad,
    // Bus drive and frame position
    output logic o_line1,
    output logic o_line2,
    output logic [7:0] o_step
);
    int n = 0;
    int last;
    int len;
    logic [1:0] sum;
    logic [1:0] p;
    logic [2:0] t;

    // Quiet bus until the first frame
    initial begin
        o_line1 = 1'b0;
        o_line2 = 1'b0;
        o_step = 8'h00;
    end

    // ----------------------------------------------------------------
    // Frame player
    // ----------------------------------------------------------------
    // Position keeps counting past the end so late pulses can be timed
    always @(posedge i_clk) begin
        last = (i_mode == 2'h0) ? 9 : 16;
        len = (i_mode == 2'h0) ? 14 : (i_mode != 2'h3 || i_cs_pair[0]) ? 21 : 34;
        sum = 2'h0;
        for (int k = 6; k <= last; k++) begin
            t = {1'b0, sum} + {1'b0, 2'(k * 3)};
            sum = (k < last) ? t[1:0] + {1'b0, t[2]} : t[1:0];
        end
        if (i_start) begin
            n = 1;
        end else if (n > 0 && n < 200) begin
            n = n + 1;
        end
        if (n == 0 || n >= len) p = 2'h0;
        else if (n == 1) p = 2'h1;
        else if (n < 6) p = {n[0], 1'b0};
        else if (n <= last) p = 2'(n * 3);
        else if (n == last + 1) p = sum ^ {1'b0, i_cs_bad};
        else if (n == last + 3) p = i_cs_pair;
        else if (n == last + 4) p = i_a1;
        else if (n == 33) p = i_a2;
        else if (n > last + 4) p = {n[0], 1'b0};
        else p = 2'h0;
        o_line1 <= p[1];
        o_line2 <= p[0];
        o_step <= 8'(n);
    end
endmodule : ibsd_bus_agent_model

// file: sim/tb.sv
// Self-checking bench for the message bus status decoder.
// Assumes the model drives the other agents; the bus is the OR of all drivers.
`timescale 1ns/1ns
module tb;
    import ibsd_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [1:0] i_msg_mode = 2'h0;
    logic i_focus_agent = 1'b0;
    logic start = 1'b0;
    logic cs_bad = 1'b0;
    logic [1:0] cs_pair = 2'h0;
    logic [1:0] a1 = 2'h0;
    logic [1:0] a2 = 2'h0;
    logic m_line1, m_line2, drv1, drv2, oe_n, upd, done, acc, rty, nofoc;
    logic [5:0] len;
    logic [7:0] step;
    logic [1:0] drv_val;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int upd_cnt, upd_step, drv_cnt, drv_step, done_cnt, done_step;
    // Wired bus: a line is high if any party drives it high
    wire bus1 = m_line1 | (~oe_n & drv1);
    wire bus2 = m_line2 | (~oe_n & drv2);

    always #5 i_clk = ~i_clk;

    ibsd_status_decoder u_ibsd_status_decoder (.i_clk(i_clk), .i_reset(i_reset), .i_bus_line1(bus1),
        .i_bus_line2(bus2), .i_msg_mode(i_msg_mode), .i_focus_agent(i_focus_agent), .o_bus_drv1(drv1),
        .o_bus_drv2(drv2), .o_bus_oe_n(oe_n), .o_arbitration_id_update(upd), .o_msg_done(done),
        .o_msg_accept(acc), .o_msg_retry(rty), .o_msg_len(len), .o_no_focus_agent(nofoc));

    ibsd_bus_agent_model u_ibsd_bus_agent_model (.i_clk(i_clk), .i_start(start), .i_mode(i_msg_mode),
        .i_cs_pair(cs_pair), .i_a1(a1), .i_a2(a2), .i_cs_bad(cs_bad), .o_line1(m_line1), .o_line2(m_line2),
        .o_step(step));

    // ----------------------------------------------------------------
    // Monitor and hang guard
    // ----------------------------------------------------------------
    // Pulses are stamped with the frame position so timing needs no guessing
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (upd === 1'b1) begin upd_cnt++; upd_step = step; end
        if (oe_n === 1'b0) begin drv_cnt++; drv_step = step; drv_val = {drv1, drv2}; end
        if (done === 1'b1) begin done_cnt++; done_step = step; end
        if (cyc > 4000) begin
            fail_count++;
            end_of_test();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // One frame through the model, then every result judged
    task run_msg(input logic [1:0] mode, input logic foc, input logic bad, input logic [1:0] cs,
                 input logic [1:0] p1, input logic [1:0] p2, input logic exp_upd, input logic [5:0] exp_len,
                 input logic exp_rty, input logic [2:0] exp_drv);
        int k;
        int d;
        d = (mode == MODE_EOI) ? 0 : 7;
        @(posedge i_clk);
        upd_cnt = 0;
        drv_cnt = 0;
        done_cnt = 0;
        i_msg_mode <= mode;
        i_focus_agent <= foc;
        cs_bad <= bad;
        cs_pair <= cs;
        a1 <= p1;
        a2 <= p2;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        k = 0;
        while (done_cnt == 0 && k < 60) begin
            @(posedge i_clk);
            k++;
        end
        @(posedge i_clk);
        check(8'(done_step), {2'h0, exp_len} + 8'h03, "end of message");
        check(8'(upd_cnt), {7'h0, exp_upd}, "id update count");
        if (exp_upd) check(8'(upd_step), 8'h10 + 8'(d), "id update cycle");
        check(8'(drv_cnt), {7'h0, exp_drv[2]}, "drive count");
        if (exp_drv[2]) begin
            check({6'h0, drv_val}, {6'h0, exp_drv[1:0]}, "drive value");
            check(8'(drv_step), 8'h0e + 8'(d), "drive cycle");
        end
        check({2'h0, len}, {2'h0, exp_len}, "length");
        check({7'h0, rty}, {7'h0, exp_rty}, "retry");
        check({7'h0, acc}, {7'h0, ~exp_rty}, "accept");
        check({7'h0, nofoc}, {7'h0, mode == MODE_LOWEST && cs == 2'h0}, "no focus flag");
        repeat (3) @(posedge i_clk);
    endtask : run_msg

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Non-lowest modes (EOI, fixed, other) share one outcome table, lengths differ
    task t_short();
        static logic [1:0] cs_t [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h1};
        static logic [1:0] a1_t [7] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 7; r++) begin
                run_msg(2'(m), 1'b0, 1'b0, cs_t[r], a1_t[r], 2'h0, r < 2, (m == 0) ? 6'h0e : 6'h15, r != 0,
                        3'h0);
            end
        end
    endtask : t_short

    task t_lowest();
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h3, 2'h2, 1'b1, 6'h22, 1'b0, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h3, 2'h3, 1'b1, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h3, 2'h0, 1'b1, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h3, 2'h1, 1'b1, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h2, 2'h2, 1'b1, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h0, 2'h2, 1'b0, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h0, 2'h1, 2'h2, 1'b0, 6'h22, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h2, 2'h0, 2'h0, 1'b1, 6'h22, 1'b0, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h3, 2'h2, 2'h2, 1'b0, 6'h15, 1'b1, 3'h0);
        run_msg(MODE_LOWEST, 1'b0, 1'b0, 2'h1, 2'h2, 2'h2, 1'b0, 6'h15, 1'b1, 3'h0);
    endtask : t_lowest

    // Own drive: corrupted checksum beats focus claim
    task t_drive();
        run_msg(MODE_FIXED, 1'b0, 1'b1, 2'h3, 2'h2, 2'h0, 1'b0, 6'h15, 1'b1, 3'h7);
        run_msg(MODE_EOI, 1'b0, 1'b1, 2'h3, 2'h2, 2'h0, 1'b0, 6'h0e, 1'b1, 3'h7);
        run_msg(MODE_LOWEST, 1'b1, 1'b0, 2'h2, 2'h0, 2'h0, 1'b1, 6'h22, 1'b0, 3'h6);
        run_msg(MODE_LOWEST, 1'b1, 1'b1, 2'h3, 2'h0, 2'h0, 1'b0, 6'h15, 1'b1, 3'h7);
    endtask : t_drive

    task end_of_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Main sequence: quiet outputs under reset, then every scenario
    initial begin
        repeat (12) @(posedge i_clk);
        check({6'h0, oe_n, upd}, 8'h02, "reset drive and update");
        check({6'h0, done, rty}, 8'h00, "reset done and retry");
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        t_short();
        t_lowest();
        t_drive();
        end_of_test();
    end
endmodule : tb
